// ==== design/uod_pkg.sv ====
// Constants for the OUT endpoint and DMA control block
// Summary of operation
// - Endpoint index selects which control set responds
// - Auto-clear drops ready after full-size unload
// - Isochronous bit selects iso or bulk operation
// - Hardware OUT DMA requests only for packets received while endpoint DMA enabled
// - Mode 0 requests DMA and interrupt per packet
// - Mode 1: full packet DMA, others interrupt
// - DMA mode bit one selects mode 1
// - Control endpoint received byte count, eight bits
// - Eleven-bit OUT count split over two offsets
// - Each endpoint FIFO has its own window
// - DMA control field picks DMA endpoint
// - DMA request mode bit: software or hardware
// - DMA direction bit: OUT zero, IN one
// - Received packet sets ready; interrupt unless mode 1 full size
// - Max packet size in units of eight bytes
`default_nettype none
package uod_pkg;
  // Bus and field widths, endpoint count
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_EP = 4;
  localparam int EP_W = 2;
  localparam int CNT_W = 11;
  localparam int DMA_EP_W = 4;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_INDEX = 12'h00e;
  localparam logic [ADDR_W-1:0] OFF_MAXPKT = 12'h013;
  localparam logic [ADDR_W-1:0] OFF_CSR1 = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CSR2 = 12'h015;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO = 12'h016;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI = 12'h017;
  localparam logic [ADDR_W-1:0] OFF_FIFO0 = 12'h020;
  localparam logic [ADDR_W-1:0] FIFO_STRIDE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_INT_EN = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_DMA = 12'h204;
  // Further OUT control field positions
  localparam int CSR2_AUTOCLR = 7;
  localparam int CSR2_ISO = 6;
  localparam int CSR2_DMAEN = 5;
  localparam int CSR2_DMAMODE = 4;
  localparam logic [7:0] CSR2_WMASK = 8'hf0;
  localparam int CSR1_READY = 0;
  // DMA control field positions
  localparam int DMA_EP_LSB = 4;
  localparam int DMA_HWMODE = 2;
  localparam int DMA_DIR = 1;
  localparam int DMA_REQ = 0;
  localparam logic [7:0] DMA_WMASK = 8'hf7;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DMA = 8'h00;
  // Max packet unit is eight bytes, a shift of three
  localparam int MAXPKT_SH = 3;
  // FIFO depths in bytes
  localparam int EP0_DEPTH = 64;
  localparam int EPX_DEPTH = 128;
endpackage : uod_pkg
`default_nettype wire

// ==== design/uod_out_dma_ctrl.sv ====
// OUT endpoint control, FIFO windows and DMA request logic
`default_nettype none

// Register map, byte offsets on the register port:
//   0x00e endpoint index, two bits
//   0x013 OUT max packet size, units of eight bytes
//   0x014 packet ready in bit 0, write zero to release
//   0x015 further OUT control: autoclear, iso, DMA enable, mode
//   0x016 received count low, control endpoint count at index 0
//   0x017 received count high, three bits
//   0x020 to 0x02c FIFO windows, one per endpoint
//   0x030 interrupt status, read only, sticky
//   0x034 interrupt enable, same layout as status
//   0x038 interrupt clear, write ones, reads zero
//   0x204 DMA control: endpoint, request mode, direction, request
//
// Hazards worth knowing:
//   Received bytes beat a software window write to one FIFO
//   A packet end beats a ready or status clear in one cycle
//   A software DMA request write beats a done pulse
//   Bytes that meet a full FIFO are dropped and not counted
//   Reading an empty window returns a stale head, no pop
//   Counts only mean something while packet ready is set
//
// Receive decision at packet end, per endpoint:
//   endpoint zero: status only
//   DMA disabled: status only
//   DMA mode 0: DMA pending and status
//   DMA mode 1, full size packet: DMA pending only
//   DMA mode 1, any other size: status only
//
// DMA request source:
//   software mode: request bit of DMA control
//   hardware mode, OUT: pending flag of chosen endpoint
//   hardware mode, IN: chosen FIFO still has room
//   hardware mode, endpoint above three: never a request

// One endpoint byte FIFO held in flip-flops
//
// Shared by three users of one endpoint:
//   the receive link pushes bytes of OUT packets
//   software pushes bytes through its window
//   software pops through its window, the link pops to send
// A push into a full FIFO is ignored.
// A pop of an empty FIFO is ignored.
// Push and pop in one cycle keep the level when neither full nor empty.
// The head byte is visible without a pop,
// so a window read sees it before the pointer moves.
//
module uod_ep_fifo #(
  parameter int DEPTH = 64
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Async reset, high
  input wire logic push, // Store one byte
  input wire logic [7:0] pushData, // Byte to store
  input wire logic pop, // Drop head byte
  output logic [7:0] headData, // Oldest byte
  output logic empty, // No byte held
  output logic full // No room left
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] level;
  } uod_fifo_st_t;

  uod_fifo_st_t st_r;
  uod_fifo_st_t st_nxt;
  logic doPush;
  logic doPop;

  // Flags and head straight from the stored state
  assign empty = (st_r.level == '0);
  assign full = (st_r.level == (AW + 1)'(DEPTH));
  assign headData = st_r.mem[st_r.rdPtr];
  assign doPush = push && !full;
  assign doPop = pop && !empty;

  // Pointer and level update
  always_comb begin
    st_nxt = st_r;
    if (doPush) begin
      st_nxt.mem[st_r.wrPtr] = pushData;
      st_nxt.wrPtr = st_r.wrPtr + 1'b1;
    end
    if (doPop) begin
      st_nxt.rdPtr = st_r.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      st_nxt.level = st_r.level + 1'b1;
    end else if (doPop && !doPush) begin
      st_nxt.level = st_r.level - 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : uod_ep_fifo

// Top of the OUT endpoint and DMA control block
module uod_out_dma_ctrl (
  input wire logic mclk, // Clock, 25 MHz
  input wire logic rst, // Async reset, high
  input wire logic [uod_pkg::ADDR_W-1:0] regAddr, // Register byte address
  input wire logic [uod_pkg::DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [uod_pkg::DATA_W-1:0] regRdata, // Read data, next cycle
  input wire logic rxValid, // Received byte strobe
  input wire logic [7:0] rxData, // Received byte
  input wire logic [uod_pkg::EP_W-1:0] rxEp, // Endpoint of rx byte
  input wire logic rxEnd, // Good packet finished
  input wire logic txPop, // Link takes a tx byte
  input wire logic [uod_pkg::EP_W-1:0] txEp, // Endpoint to send from
  output logic [7:0] txData, // Head byte for link
  output logic txEmpty, // Nothing to send
  output logic [uod_pkg::NUM_EP-1:0] isoMode, // Iso select per endpoint
  output logic dmaReq, // Request to DMA engine
  output logic [uod_pkg::DMA_EP_W-1:0] dmaEp, // DMA endpoint choice
  output logic dmaDirIn, // DMA moves IN data
  output logic dmaHwMode, // Hardware request mode
  input wire logic dmaDone, // DMA transfer finished
  output logic irq // Level interrupt
);
  import uod_pkg::*;

  // Block state, one record registered as a whole:
  //   epIndex selects the endpoint behind the shared registers
  //   csr2 holds the further OUT control per endpoint
  //   maxPkt holds max packet size per endpoint, eight byte units
  //   pktReady is the packet ready flag per endpoint
  //   dmaPend is a pending hardware DMA request per endpoint
  //   rxCnt counts bytes of the packet still arriving
  //   pktCnt holds the count of the last finished packet
  //   unloadCnt counts bytes read back through the window
  //   dmaCtl is the DMA control byte
  //   intStat and intEn are the sticky status and its enable
  //   rdData is the read answer, standing one cycle
  typedef struct packed {
    logic [EP_W-1:0] epIndex;
    logic [NUM_EP-1:0][7:0] csr2;
    logic [NUM_EP-1:0][7:0] maxPkt;
    logic [NUM_EP-1:0] pktReady;
    logic [NUM_EP-1:0] dmaPend;
    logic [NUM_EP-1:0][CNT_W-1:0] rxCnt;
    logic [NUM_EP-1:0][CNT_W-1:0] pktCnt;
    logic [NUM_EP-1:0][CNT_W-1:0] unloadCnt;
    logic [7:0] dmaCtl;
    logic [NUM_EP-1:0] intStat;
    logic [NUM_EP-1:0] intEn;
    logic [DATA_W-1:0] rdData;
  } uod_state_t;

  uod_state_t st_r;
  uod_state_t st_nxt;

  logic [NUM_EP-1:0] winWr;
  logic [NUM_EP-1:0] winRd;
  logic [NUM_EP-1:0] fifoPush;
  logic [NUM_EP-1:0] fifoPop;
  logic [NUM_EP-1:0] fifoEmpty;
  logic [NUM_EP-1:0] fifoFull;
  logic [NUM_EP-1:0][7:0] fifoHead;
  logic [NUM_EP-1:0][7:0] pushByte;
  logic [EP_W-1:0] sel;
  logic [DMA_EP_W-1:0] dmaSel;
  logic dmaSelOk;

  assign sel = st_r.epIndex;
  assign dmaSel = st_r.dmaCtl[DMA_EP_LSB +: DMA_EP_W];
  assign dmaSelOk = (dmaSel < DMA_EP_W'(NUM_EP));

  // Endpoint FIFOs, one window each
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    localparam logic [ADDR_W-1:0] WIN = OFF_FIFO0 + ADDR_W'(i) * FIFO_STRIDE;
    assign winWr[i] = regWr && (regAddr == WIN);
    assign winRd[i] = regRd && (regAddr == WIN);
    // Received bytes win over a software push in the same cycle
    assign fifoPush[i] = (rxValid && (rxEp == EP_W'(i))) || winWr[i];
    assign pushByte[i] = (rxValid && (rxEp == EP_W'(i))) ? rxData
                                                         : regWdata[7:0];
    assign fifoPop[i] = winRd[i] || (txPop && (txEp == EP_W'(i)));
    uod_ep_fifo #(
      .DEPTH((i == 0) ? EP0_DEPTH : EPX_DEPTH)
    ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .push(fifoPush[i]),
      .pushData(pushByte[i]),
      .pop(fifoPop[i]),
      .headData(fifoHead[i]),
      .empty(fifoEmpty[i]),
      .full(fifoFull[i])
    );
    // Endpoint zero is a control endpoint and never isochronous
    assign isoMode[i] = (i != 0) && st_r.csr2[i][CSR2_ISO];
  end


  // Link side transmit view
  // Head and empty follow txEp at once, no register between
  assign txData = fifoHead[txEp];
  assign txEmpty = fifoEmpty[txEp];

  // DMA control outputs
  assign dmaEp = dmaSel;
  assign dmaDirIn = st_r.dmaCtl[DMA_DIR];
  assign dmaHwMode = st_r.dmaCtl[DMA_HWMODE];


  // Request source depends on request mode and direction
  // Level request; it drops by itself once the cause is gone
  always_comb begin
    dmaReq = 1'b0;
    if (!st_r.dmaCtl[DMA_HWMODE]) begin
      dmaReq = st_r.dmaCtl[DMA_REQ];
    end else if (dmaSelOk) begin
      if (!st_r.dmaCtl[DMA_DIR]) begin
        dmaReq = st_r.dmaPend[dmaSel[EP_W-1:0]];
      end else begin
        dmaReq = !fifoFull[dmaSel[EP_W-1:0]];
      end
    end
  end

  // Interrupt line
  assign irq = |(st_r.intStat & st_r.intEn);
  assign regRdata = st_r.rdData;


  // Next state: bus writes, unload tracking, packet arrival, reads
  //
  // Order of the parts below sets the priorities:
  //   register writes first
  //   then a done pulse on the software request
  //   then automatic release of fully unloaded packets
  //   then byte counting of the packet in progress
  //   then packet arrival, which must win over any clear
  //   then the read answer, built from the old state
  //
  // Writes to max packet size and further control are
  // dropped at index zero, as the control endpoint has
  // neither; its iso output therefore stays low.
  //
  always_comb begin
    logic [CNT_W-1:0] maxBytes;
    logic [CNT_W-1:0] rxMax;
    logic [CNT_W-1:0] unloaded;
    st_nxt = st_r;
    maxBytes = '0;
    rxMax = '0;
    unloaded = '0;
    st_nxt.rdData = '0;

    // Register writes through the selected endpoint
    if (regWr) begin
      unique case (regAddr)
        OFF_INDEX: st_nxt.epIndex = regWdata[EP_W-1:0];
        OFF_MAXPKT: begin
          if (sel != '0) begin
            st_nxt.maxPkt[sel] = regWdata[7:0];
          end
        end
        OFF_CSR1: begin
          // Writing zero to the ready bit releases the packet
          if (!regWdata[CSR1_READY]) begin
            st_nxt.pktReady[sel] = 1'b0;
            st_nxt.dmaPend[sel] = 1'b0;
            st_nxt.unloadCnt[sel] = '0;
          end
        end
        OFF_CSR2: begin
          if (sel != '0) begin
            st_nxt.csr2[sel] = regWdata[7:0] & CSR2_WMASK;
          end
        end
        OFF_DMA: st_nxt.dmaCtl = regWdata[7:0] & DMA_WMASK;
        OFF_INT_EN: st_nxt.intEn = regWdata[NUM_EP-1:0];
        OFF_INT_CLR: st_nxt.intStat = st_r.intStat & ~regWdata[NUM_EP-1:0];
        default: ;
      endcase
    end

    // Finished transfer drops the software request unless rewritten
    if (dmaDone && !(regWr && (regAddr == OFF_DMA))) begin
      st_nxt.dmaCtl[DMA_REQ] = 1'b0;
    end

    // Unload tracking and automatic release of full packets
    for (int e = 1; e < NUM_EP; e++) begin
      if (winRd[e] && !fifoEmpty[e] && st_r.pktReady[e]) begin
        maxBytes = CNT_W'(st_r.maxPkt[e]) << MAXPKT_SH;
        unloaded = CNT_W'(st_r.unloadCnt[e] + 11'd1);
        st_nxt.unloadCnt[e] = unloaded;
        if (st_r.csr2[e][CSR2_AUTOCLR] && (maxBytes != '0) &&
            (st_r.pktCnt[e] == maxBytes) && (unloaded == maxBytes)) begin
          st_nxt.pktReady[e] = 1'b0;
          st_nxt.dmaPend[e] = 1'b0;
          st_nxt.unloadCnt[e] = '0;
        end
      end
    end

    // Count bytes actually stored for the packet in progress
    if (rxValid && !fifoFull[rxEp]) begin
      st_nxt.rxCnt[rxEp] = CNT_W'(st_r.rxCnt[rxEp] + 11'd1);
    end

    // Packet arrival; placed after the clears so it wins over a clear
    if (rxEnd) begin
      rxMax = CNT_W'(st_r.maxPkt[rxEp]) << MAXPKT_SH;
      st_nxt.pktCnt[rxEp] = st_r.rxCnt[rxEp];
      st_nxt.rxCnt[rxEp] = '0;
      st_nxt.unloadCnt[rxEp] = '0;
      st_nxt.pktReady[rxEp] = 1'b1;
      if (rxEp == '0) begin
        st_nxt.intStat[0] = 1'b1;
      end else if (!st_r.csr2[rxEp][CSR2_DMAEN]) begin
        st_nxt.intStat[rxEp] = 1'b1;
      end else if (!st_r.csr2[rxEp][CSR2_DMAMODE]) begin
        st_nxt.dmaPend[rxEp] = 1'b1;
        st_nxt.intStat[rxEp] = 1'b1;
      end else if (st_r.rxCnt[rxEp] == rxMax) begin
        st_nxt.dmaPend[rxEp] = 1'b1;
      end else begin
        st_nxt.intStat[rxEp] = 1'b1;
      end
    end

    // Read data, valid the cycle after the strobe only
    if (regRd) begin
      unique case (regAddr)
        OFF_INDEX: st_nxt.rdData = DATA_W'(st_r.epIndex);
        OFF_MAXPKT: st_nxt.rdData = DATA_W'(st_r.maxPkt[sel]);
        OFF_CSR1: st_nxt.rdData = DATA_W'(st_r.pktReady[sel]);
        OFF_CSR2: st_nxt.rdData = DATA_W'(st_r.csr2[sel]);
        OFF_CNT_LO: st_nxt.rdData = DATA_W'(st_r.pktCnt[sel][7:0]);
        OFF_CNT_HI: st_nxt.rdData = DATA_W'(st_r.pktCnt[sel][10:8]);
        OFF_DMA: st_nxt.rdData = DATA_W'(st_r.dmaCtl);
        OFF_INT_STAT: st_nxt.rdData = DATA_W'(st_r.intStat);
        OFF_INT_EN: st_nxt.rdData = DATA_W'(st_r.intEn);
        default: begin
          for (int w = 0; w < NUM_EP; w++) begin
            if (winRd[w]) begin
              st_nxt.rdData = DATA_W'(fifoHead[w]);
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : uod_out_dma_ctrl
`default_nettype wire

// ==== verification/uod_ctrl_assertions.sv ====
// Port checker for the OUT endpoint and DMA control block
`default_nettype none
module uod_ctrl_assertions (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic [uod_pkg::ADDR_W-1:0] regAddr, // Address
  input wire logic [uod_pkg::DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [uod_pkg::DATA_W-1:0] regRdata, // Read data
  input wire logic [uod_pkg::NUM_EP-1:0] isoMode, // Iso bits
  input wire logic dmaReq, // DMA request
  input wire logic [uod_pkg::DMA_EP_W-1:0] dmaEp, // DMA endpoint
  input wire logic dmaHwMode, // Hardware mode
  input wire logic dmaDirIn, // Direction
  input wire logic dmaDone // DMA finished
);
  import uod_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic dmaW;
  // Write to the DMA control register
  assign dmaW = regWr && regAddr == OFF_DMA;
  // DMA control fields and request behaviour
  property p_dmaEp; dmaW |=> dmaEp == $past(regWdata[7:4]); endproperty
  a_dmaEp: assert property (p_dmaEp) else $error("dma ep wrong");
  property p_dmaMode; dmaW |=> dmaHwMode == $past(regWdata[2]); endproperty
  a_dmaMode: assert property (p_dmaMode) else $error("mode wrong");
  property p_dmaDir; dmaW |=> dmaDirIn == $past(regWdata[1]); endproperty
  a_dmaDir: assert property (p_dmaDir) else $error("dir wrong");
  property p_swReq; dmaW && !regWdata[2] && regWdata[7:4] < 4'h4
    |=> dmaReq == $past(regWdata[0]); endproperty
  a_swReq: assert property (p_swReq) else $error("sw req wrong");
  property p_swDone; !dmaHwMode && dmaDone && !dmaW |=> !dmaReq; endproperty
  a_swDone: assert property (p_swDone) else $error("req stuck");
  property p_hwEp; dmaHwMode && dmaEp > 4'h3 |-> !dmaReq; endproperty
  a_hwEp: assert property (p_hwEp) else $error("req bad ep");
  property p_iso0; isoMode[0] == 1'b0; endproperty
  a_iso0: assert property (p_iso0) else $error("iso on ep0");
  property p_dmaRsv; regRd && regAddr == OFF_DMA
    |=> regRdata[31:8] == '0 && !regRdata[3]; endproperty
  a_dmaRsv: assert property (p_dmaRsv) else $error("reserved set");
  // Main scenarios
  c_hwReq: cover property (dmaHwMode && dmaReq);
  c_swReq: cover property (!dmaHwMode && dmaReq ##1 dmaDone);
  c_iso: cover property (isoMode != '0);
endmodule : uod_ctrl_assertions
bind uod_out_dma_ctrl uod_ctrl_assertions u_uod_ctrl_assertions (.mclk,
  .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .isoMode, .dmaReq,
  .dmaEp, .dmaHwMode, .dmaDirIn, .dmaDone);
`default_nettype wire

// ==== verification/uod_link_model.sv ====
// Behavioural link side: received packets and transmit pops
`default_nettype none
module uod_link_model (
  input wire logic mclk, // Clock
  output logic rxValid, // Byte strobe
  output logic [7:0] rxData, // Byte
  output logic [uod_pkg::EP_W-1:0] rxEp, // Endpoint
  output logic rxEnd, // Packet end
  output logic txPop, // Take tx byte
  output logic [uod_pkg::EP_W-1:0] txEp // Tx endpoint
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels, sending always from endpoint 3
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxEp = '0;
    rxEnd = 1'b0;
    txPop = 1'b0;
    txEp = 2'h3;
  end
  // Bytes, then an end strobe; data line garbled when idle
  task automatic send(input logic [1:0] ep, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rxValid <= 1'b1;
      rxEp <= ep;
      rxData <= b + 8'(i);
    end
    @(posedge mclk);
    rxValid <= 1'b0;
    rxEnd <= 1'b1;
    rxData <= ~rxData;
    @(posedge mclk);
    rxEnd <= 1'b0;
    #1;
  endtask : send
  // One byte taken by the link
  task automatic pop();
    @(posedge mclk);
    txPop <= 1'b1;
    @(posedge mclk);
    txPop <= 1'b0;
    #1;
  endtask : pop
endmodule : uod_link_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the OUT endpoint and DMA control block
`default_nettype none
module tb_top import uod_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] EP1W = OFF_FIFO0 + FIFO_STRIDE;
  localparam logic [11:0] EP3W = OFF_FIFO0 + 12'h00c;
  logic mclk, rst, regWr, regRd, rxValid, rxEnd, txPop, dmaDone;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic [7:0] rxData, txData;
  logic [EP_W-1:0] rxEp, txEp;
  logic [NUM_EP-1:0] isoMode;
  logic [DMA_EP_W-1:0] dmaEp;
  logic txEmpty, dmaReq, dmaDirIn, dmaHwMode, irq;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  uod_out_dma_ctrl u_uod_out_dma_ctrl (.mclk, .rst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .rxValid, .rxData, .rxEp, .rxEnd, .txPop,
    .txEp, .txData, .txEmpty, .isoMode, .dmaReq, .dmaEp, .dmaDirIn,
    .dmaHwMode, .dmaDone, .irq);
  uod_link_model u_uod_link_model (.mclk, .rxValid, .rxData, .rxEp, .rxEnd,
    .txPop, .txEp);
  // Clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rd
  task automatic drain(input logic [11:0] a, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) rd(a, 32'(b + 8'(i)));
  endtask : drain
  task automatic finish_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    dmaDone = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(OFF_CNT_LO, 0);
    rd(OFF_DMA, 0);
    rd(12'h100, 0);
    wr(OFF_INDEX, 1);
    wr(OFF_MAXPKT, 1);
    wr(OFF_CSR2, 32'hff);
    rd(OFF_CSR2, 32'hf0);
    chk(32'(isoMode), 2);
    wr(OFF_INDEX, 2);
    rd(OFF_CSR2, 0);
    wr(OFF_INDEX, 1);
    wr(OFF_CSR2, 32'hb0);
    wr(OFF_DMA, 32'h14);
    wr(OFF_INT_EN, 32'hff);
    u_uod_link_model.send(2'h1, 8, 8'h10);
    chk(32'({dmaReq, irq}), 2);
    rd(OFF_CNT_LO, 8);
    rd(OFF_CNT_HI, 0);
    rd(OFF_CSR1, 1);
    drain(EP1W, 8, 8'h10);
    chk(32'(dmaReq), 0);
    rd(OFF_CSR1, 0);
    u_uod_link_model.send(2'h1, 3, 8'h20);
    chk(32'({dmaReq, irq}), 1);
    wr(OFF_INT_EN, 0);
    chk(32'(irq), 0);
    wr(OFF_INT_EN, 32'hff);
    drain(EP1W, 3, 8'h20);
    rd(OFF_CSR1, 1);
    wr(OFF_CSR1, 0);
    wr(OFF_INT_CLR, 32'hff);
    chk(32'(irq), 0);
    wr(OFF_CSR2, 32'ha0);
    u_uod_link_model.send(2'h1, 2, 8'h30);
    chk(32'({dmaReq, irq}), 3);
    drain(EP1W, 2, 8'h30);
    wr(OFF_CSR1, 0);
    wr(OFF_INT_CLR, 32'hff);
    wr(OFF_CSR2, 32'h90);
    u_uod_link_model.send(2'h1, 8, 8'h40);
    chk(32'({dmaReq, irq}), 1);
    drain(EP1W, 8, 8'h40);
    wr(OFF_INDEX, 2);
    u_uod_link_model.send(2'h2, 130, 8'h00);
    rd(OFF_CNT_LO, 32'h80);
    wr(OFF_DMA, 32'h26);
    chk(32'(dmaReq), 0);
    wr(OFF_DMA, 32'h36);
    chk(32'(dmaReq), 1);
    u_uod_link_model.send(2'h0, 5, 8'h50);
    wr(OFF_INDEX, 0);
    rd(OFF_CNT_LO, 5);
    rd(OFF_FIFO0, 32'h50);
    wr(EP3W, 32'h5a);
    wr(EP3W, 32'ha5);
    chk(32'({txEmpty, txData}), 32'h05a);
    u_uod_link_model.pop();
    chk(32'({txEmpty, txData}), 32'h0a5);
    u_uod_link_model.pop();
    chk(32'(txEmpty), 1);
    wr(OFF_DMA, 32'h01);
    chk(32'(dmaReq), 1);
    @(posedge mclk) dmaDone <= 1'b1;
    @(posedge mclk) dmaDone <= 1'b0;
    #1;
    chk(32'(dmaReq), 0);
    wr(OFF_DMA, 32'hf6);
    chk(32'({dmaEp, dmaHwMode, dmaDirIn, dmaReq}), 32'h7e);
    rd(OFF_DMA, 32'hf6);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
